// ### cdr_defines.vh
// Purpose: Shared constants of the conversion data readout port
// Assumes: Master clock of the converter is the block clock (25 MHz)
// Notes:   Counts are in block clock cycles
`ifndef CDR_DEFINES_VH
`define CDR_DEFINES_VH

// Block clock periods per master clock period
`define CDR_MCLK_PER_CLK     1
// Autoreset timeout, in master clock periods
`define CDR_TIMEOUT_TCLK     65536
`define CDR_TIMEOUT_CYC      (`CDR_TIMEOUT_TCLK * `CDR_MCLK_PER_CLK)
// Transitions that must follow the first rising edge
`define CDR_TRANS_NEEDED     3'h7
// Recovery after an autoreset, in master clock periods
`define CDR_RECOVER_TCLK     4
`define CDR_RECOVER_CYC      (`CDR_RECOVER_TCLK * `CDR_MCLK_PER_CLK)
// High pulse of the ready output before an unread result is replaced
`define CDR_PULSE_TCLK       16
`define CDR_PULSE_CYC        (`CDR_PULSE_TCLK * `CDR_MCLK_PER_CLK)

// Command bytes
`define CDR_CMD_PRIM_A       8'h12
`define CDR_CMD_PRIM_B       8'h13
`define CDR_CMD_AUX_A        8'h14
`define CDR_CMD_AUX_B        8'h15
`define CDR_CMD_NOP          8'h00
// Constant pad byte of the auxiliary block
`define CDR_PAD_BYTE         8'h00
// Checksum start value
`define CDR_CHK_SEED         8'h00
// Status byte fields
`define CDR_ST_AUX_NEW       7
`define CDR_ST_PRIM_NEW      6
// Result widths and buffer shape
`define CDR_PRIM_W           32
`define CDR_AUX_W            24
`define CDR_FIFO_DEPTH       8
`define CDR_FIFO_AW          3

`endif

// ### cdr_fifo.v
// Purpose: Small synchronous FIFO for conversion results
// Assumes: Single clock; push and pop may happen in the same cycle
// Notes:   Full and empty flags are registered
`timescale 1ns/10ps
`default_nettype none

module cdr_fifo #(
    parameter WIDTH = 32,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    // Clock and reset
    input  wire             clock,
    input  wire             reset_n,
    // Fill side
    input  wire             in_valid,
    output reg              in_ready,
    input  wire [WIDTH-1:0] in_data,
    // Drain side
    output reg              out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);

reg [WIDTH-1:0] mem [0:DEPTH-1];
reg [AW-1:0]    wr_ptr;
reg [AW-1:0]    rd_ptr;
reg [AW:0]      count;

wire            push = in_valid & in_ready;
wire            pop  = out_valid & out_ready;
reg  [AW:0]     next_count;

assign out_data = mem[rd_ptr];

always @* begin
    next_count = count;
    if (push & ~pop) begin
        next_count = count + 1'b1;
    end else if (pop & ~push) begin
        next_count = count - 1'b1;
    end
end

always @(posedge clock) begin
    if (push) begin
        mem[wr_ptr] <= in_data;
    end
end

always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
        wr_ptr    <= {AW{1'b0}};
        rd_ptr    <= {AW{1'b0}};
        count     <= {(AW+1){1'b0}};
        in_ready  <= 1'b0;
        out_valid <= 1'b0;
    end else begin
        if (push) begin
            wr_ptr <= (wr_ptr == DEPTH - 1) ? {AW{1'b0}} : wr_ptr + 1'b1;
        end
        if (pop) begin
            rd_ptr <= (rd_ptr == DEPTH - 1) ? {AW{1'b0}} : rd_ptr + 1'b1;
        end
        count     <= next_count;
        in_ready  <= (next_count != DEPTH);
        out_valid <= (next_count != {(AW+1){1'b0}});
    end
end

endmodule
`default_nettype wire

// ### cdr_readout_port.v
// Purpose: Serial readout of conversion results with ready signalling
// Assumes: Serial pins are asynchronous and sampled by the block clock
// Notes:   Primary results arrive through a FIFO; other commands are passed out
// Functional notes
// - Timeout enabled: serial reset after 65536 periods
// - Ready high at reset, low per result
// - Continuous: first falling clock edge returns ready
// - Unread: ready pulses high 16 periods first
// - Next ready fall replaces earlier primary result
// - Pulse mode: high at start, low when ready
// - Shared pin follows ready while chip selected
// - New-data flag per converter, cleared by read
// - Auxiliary flag valid only in command readout
// - Primary to shifter and holding; auxiliary holding only
// - Commands decoded during direct readout; data-in low
// - Busy interface: new result to holding only
// - Configuration restart discards existing result
// - Four bytes, optional status, checksum; repeats
// - Command readout: MSB on first rising edge
// - Auxiliary: status, three bytes, pad 00h, checksum
// - Fresh command per read; others ignored meanwhile
// - 12h/13h read primary, 14h/15h auxiliary
// - Command readout: opcode falling edge returns ready
// - Seven transitions after rising edge restart counting
// - Timeout enable input, off after reset
// - Chip select high resets interface, releases pin
// - Sample data-in falling, drive output rising
`timescale 1ns/10ps
`default_nettype none
`include "cdr_defines.vh"

module cdr_readout_port #(
    parameter [16:0] TIMEOUT_CYCLES = `CDR_TIMEOUT_CYC
) (
    // Clock and reset
    input  wire        clock,
    input  wire        reset_n,
    // Serial pins
    input  wire        cs_n_pin,
    input  wire        sclk_pin,
    input  wire        din_pin,
    output reg         shared_out_ready_pin,
    output reg         shared_out_ready_pin_oe,
    output reg         ready_out_n,
    // Configuration
    input  wire        timeout_enable,
    input  wire        status_enable,
    input  wire        checksum_enable,
    input  wire        pulse_mode,
    input  wire        reg_access_busy,
    input  wire        config_restart,
    input  wire        conversion_start,
    input  wire [5:0]  status_low,
    // Primary converter results
    input  wire        prim_valid,
    output wire        prim_ready,
    input  wire [31:0] prim_data,
    // Auxiliary converter results
    input  wire        aux_valid,
    input  wire [23:0] aux_data,
    // Commands passed to the command decoder
    output reg         cmd_strobe,
    output reg  [7:0]  cmd_byte
);

localparam ST_DIRECT = 1'b0;
localparam ST_CMD    = 1'b1;
localparam [31:0] RECOVER_CYC = `CDR_RECOVER_CYC, PULSE_CYC = `CDR_PULSE_CYC;

////////////////////////////////////////////////////////////////////////////////
// Pin synchronisers

reg cs_s1, cs_s2, sclk_s1, sclk_s2, sclk_s3, din_s1, din_s2;

always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
        cs_s1   <= 1'b1;
        cs_s2   <= 1'b1;
        sclk_s1 <= 1'b0;
        sclk_s2 <= 1'b0;
        sclk_s3 <= 1'b0;
        din_s1  <= 1'b0;
        din_s2  <= 1'b0;
    end else begin
        cs_s1   <= cs_n_pin;
        cs_s2   <= cs_s1;
        sclk_s1 <= sclk_pin;
        sclk_s2 <= sclk_s1;
        sclk_s3 <= sclk_s2;
        din_s1  <= din_pin;
        din_s2  <= din_s1;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Result buffer

wire        f_valid;
wire [31:0] f_data;
wire        f_pop;

cdr_fifo #(
    .WIDTH (`CDR_PRIM_W),
    .DEPTH (`CDR_FIFO_DEPTH),
    .AW    (`CDR_FIFO_AW)
) u_fifo (
    .clock     (clock),
    .reset_n   (reset_n),
    .in_valid  (prim_valid),
    .in_ready  (prim_ready),
    .in_data   (prim_data),
    .out_valid (f_valid),
    .out_ready (f_pop),
    .out_data  (f_data)
);

////////////////////////////////////////////////////////////////////////////////
// Autoreset and edge qualification

reg        to_run;
reg [16:0] to_timer;
reg [2:0]  to_trans;
reg [2:0]  guard_cnt;

wire cs_act   = ~cs_s2;
wire raw_rise = sclk_s2 & ~sclk_s3;
wire raw_fall = ~sclk_s2 & sclk_s3;
wire to_fire  = to_run & (to_timer == TIMEOUT_CYCLES - 17'h1);
wire edge_ok  = cs_act & (guard_cnt == 3'h0);
wire rise     = raw_rise & edge_ok;
wire fall     = raw_fall & edge_ok;
wire ser_rst  = ~cs_act | to_fire;

always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
        to_run    <= 1'b0;
        to_timer  <= 17'h0;
        to_trans  <= 3'h0;
        guard_cnt <= 3'h0;
    end else begin
        if (guard_cnt != 3'h0) begin
            guard_cnt <= guard_cnt - 3'h1;
        end
        if (!timeout_enable || !cs_act) begin
            to_run <= 1'b0;
        end else if (to_fire) begin
            to_run    <= 1'b0;
            guard_cnt <= RECOVER_CYC[2:0];
        end else if (!to_run) begin
            if (rise) begin
                to_run   <= 1'b1;
                to_timer <= 17'h0;
                to_trans <= 3'h0;
            end
        end else begin
            to_timer <= to_timer + 17'h1;
            if (rise | fall) begin
                if (to_trans == `CDR_TRANS_NEEDED - 3'h1) begin
                    to_run <= 1'b0;
                end
                to_trans <= to_trans + 3'h1;
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Byte sequence

function [7:0] byte_at;
    input [2:0]  pos;
    input [31:0] word;
    input [7:0]  status;
    input        st_en;
    input        aux;
    reg   [2:0]  idx;
    reg   [7:0]  lo;
    begin
        idx = pos - {2'b00, st_en};
        lo  = aux ? `CDR_PAD_BYTE : word[7:0];
        if (st_en && pos == 3'h0) begin
            byte_at = status;
        end else begin
            case (idx)
                3'h0:    byte_at = word[31:24];
                3'h1:    byte_at = word[23:16];
                3'h2:    byte_at = word[15:8];
                3'h3:    byte_at = lo;
                default: byte_at = `CDR_CHK_SEED + word[31:24] + word[23:16] + word[15:8] + lo;
            endcase
        end
    end
endfunction

reg        state;
reg        cmd_aux;
reg [2:0]  bit_pos;
reg [2:0]  byte_pos;
reg [7:0]  rx_byte;
reg        shifting;
reg [31:0] hold_prim;
reg [31:0] out_shift;
reg [23:0] hold_aux;
reg        prim_new;
reg        aux_new;
reg [31:0] cmd_word;
reg [7:0]  cmd_status;
reg [4:0]  pulse_cnt;

wire [2:0] seq_len  = 3'h4 + {2'b00, status_enable} + {2'b00, checksum_enable};
wire [7:0] dir_stat = {1'b0, prim_new, status_low};
wire [7:0] cur_byte = (state == ST_CMD)
                    ? byte_at(byte_pos, cmd_word, cmd_status, status_enable, cmd_aux)
                    : byte_at(byte_pos, out_shift, dir_stat, status_enable, 1'b0);
wire       last_bit = (bit_pos == 3'h7);
wire       seq_end  = last_bit & (byte_pos == seq_len - 3'h1);
wire [7:0] rx_full  = {rx_byte[6:0], din_s2};
wire       busy     = shifting | (state == ST_CMD) | reg_access_busy;
wire       hold_off = ~pulse_mode & ~ready_out_n;

assign f_pop = f_valid & ((pulse_cnt != 5'h0) ? (pulse_cnt == 5'h1) : ~hold_off);

////////////////////////////////////////////////////////////////////////////////
// Ready signalling

reg next_ready;
reg next_shift;

always @* begin
    next_ready = ready_out_n;
    next_shift = shifting;
    if (ser_rst) begin
        next_shift = 1'b0;
    end else if (rise) begin
        next_shift = 1'b1;
    end else if (fall && seq_end) begin
        next_shift = 1'b0;
    end
    if (fall && !pulse_mode) begin
        next_ready = 1'b1;
    end
    if (pulse_mode && conversion_start) begin
        next_ready = 1'b1;
    end
    if (f_valid && pulse_cnt == 5'h0 && hold_off) begin
        next_ready = 1'b1;
    end
    if (config_restart) begin
        next_ready = 1'b1;
    end
    if (f_pop && !config_restart) begin
        next_ready = 1'b0;
        if (!busy) begin
            next_shift = 1'b0;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Serial engine and result registers

always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
        ready_out_n             <= 1'b1;
        shared_out_ready_pin    <= 1'b1;
        shared_out_ready_pin_oe <= 1'b0;
        cmd_strobe              <= 1'b0;
        cmd_byte                <= 8'h00;
        state                   <= ST_DIRECT;
        cmd_aux                 <= 1'b0;
        bit_pos                 <= 3'h0;
        byte_pos                <= 3'h0;
        rx_byte                 <= 8'h00;
        shifting                <= 1'b0;
        hold_prim               <= 32'h0;
        out_shift               <= 32'h0;
        hold_aux                <= 24'h0;
        prim_new                <= 1'b0;
        aux_new                 <= 1'b0;
        cmd_word                <= 32'h0;
        cmd_status              <= 8'h00;
        pulse_cnt               <= 5'h0;
    end else begin
        cmd_strobe              <= 1'b0;
        ready_out_n             <= next_ready;
        shifting                <= next_shift;
        shared_out_ready_pin_oe <= cs_act;
        if (ser_rst) begin
            state    <= ST_DIRECT;
            bit_pos  <= 3'h0;
            byte_pos <= 3'h0;
            rx_byte  <= 8'h00;
        end else if (fall) begin
            rx_byte <= rx_full;
            bit_pos <= bit_pos + 3'h1;
            if (last_bit) begin
                byte_pos <= seq_end ? 3'h0 : byte_pos + 3'h1;
                if (state == ST_CMD) begin
                    if (seq_end) begin
                        state <= ST_DIRECT;
                    end
                end else if (rx_full == `CDR_CMD_PRIM_A || rx_full == `CDR_CMD_PRIM_B) begin
                    state      <= ST_CMD;
                    cmd_aux    <= 1'b0;
                    byte_pos   <= 3'h0;
                    cmd_word   <= hold_prim;
                    cmd_status <= {aux_new, prim_new, status_low};
                    prim_new   <= 1'b0;
                end else if (rx_full == `CDR_CMD_AUX_A || rx_full == `CDR_CMD_AUX_B) begin
                    state      <= ST_CMD;
                    cmd_aux    <= 1'b1;
                    byte_pos   <= 3'h0;
                    cmd_word   <= {hold_aux, `CDR_PAD_BYTE};
                    cmd_status <= {aux_new, prim_new, 6'h00};
                    aux_new    <= 1'b0;
                end else begin
                    if (rx_full != `CDR_CMD_NOP) begin
                        cmd_strobe <= 1'b1;
                        cmd_byte   <= rx_full;
                    end
                    if (seq_end) begin
                        prim_new <= 1'b0;
                    end
                end
            end
        end
        // Pin holds the last data bit until, with no readout shifting, the ready level moves or a serial reset occurs
        if (rise && !ser_rst) begin
            shared_out_ready_pin <= cur_byte[~bit_pos];
        end else if (!next_shift && (ser_rst || next_ready != ready_out_n)) begin
            shared_out_ready_pin <= next_ready;
        end
        // Pulse ahead of replacing an unread result
        if (config_restart) begin
            pulse_cnt <= 5'h0;
        end else if (pulse_cnt != 5'h0) begin
            pulse_cnt <= pulse_cnt - 5'h1;
        end else if (f_valid && hold_off) begin
            pulse_cnt <= PULSE_CYC[4:0];
        end
        if (aux_valid) begin
            hold_aux <= aux_data;
            aux_new  <= 1'b1;
        end
        if (config_restart) begin
            hold_prim <= 32'h0;
            out_shift <= 32'h0;
            prim_new  <= 1'b0;
        end else if (f_pop) begin
            hold_prim <= f_data;
            prim_new  <= 1'b1;
            if (!busy) begin
                out_shift <= f_data;
                byte_pos  <= 3'h0;
                bit_pos   <= 3'h0;
            end
        end
    end
end

endmodule
`default_nettype wire

// ### cdr_readout_port_asserts.sv
// Purpose: Timing relations of the readout port seen at its pins
// Assumes: Single clock domain, asynchronous active-low reset
// Notes:   Bound into every readout port instance
`timescale 1ns/10ps
`default_nettype none
module cdr_port_chk #(parameter [16:0] TIMEOUT_CYCLES = 17'h10000) (
    // Clock and reset
    input wire logic       clock,
    input wire logic       reset_n,
    // Pins and controls watched
    input wire logic       cs_n_pin,
    input wire logic       shared_out_ready_pin,
    input wire logic       shared_out_ready_pin_oe,
    input wire logic       ready_out_n,
    input wire logic       pulse_mode,
    input wire logic       config_restart,
    input wire logic       conversion_start,
    input wire logic       cmd_strobe,
    input wire logic [7:0] cmd_byte
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);

    a_reset_idle: assert property ($rose(reset_n) |-> ready_out_n && !shared_out_ready_pin_oe)
        else $error("ready or pin enable wrong after reset");
    a_oe_release: assert property (cs_n_pin [*3] |=> !shared_out_ready_pin_oe)
        else $error("pin still driven with chip select high");
    a_oe_drive: assert property (!cs_n_pin [*4] |=> shared_out_ready_pin_oe)
        else $error("pin not driven with chip select low");
    a_pin_with_ready: assert property ($fell(ready_out_n) && shared_out_ready_pin_oe |-> !shared_out_ready_pin)
        else $error("shared pin did not fall with ready");
    a_unread_pulse: assert property ($fell(ready_out_n) && !pulse_mode |-> $past(ready_out_n, 16))
        else $error("ready high pulse shorter than sixteen cycles");
    a_pulse_start: assert property (pulse_mode && conversion_start |=> ready_out_n)
        else $error("ready not high after conversion start");
    a_pulse_hold: assert property (pulse_mode && !ready_out_n && !conversion_start && !config_restart
        |=> !ready_out_n)
        else $error("ready left low state without conversion start");
    a_restart_high: assert property (config_restart |=> ready_out_n)
        else $error("ready not high after restart");
    a_strobe_single: assert property (cmd_strobe |=> !cmd_strobe)
        else $error("command strobe longer than one cycle");
    a_no_read_fwd: assert property (cmd_strobe |-> cmd_byte != 8'h00 && cmd_byte[7:1] != 7'h09
        && cmd_byte[7:1] != 7'h0a)
        else $error("read or empty byte forwarded as command");
endmodule
bind cdr_readout_port cdr_port_chk #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) chk_u (.clock(clock), .reset_n(reset_n),
    .cs_n_pin(cs_n_pin), .shared_out_ready_pin(shared_out_ready_pin), .shared_out_ready_pin_oe(shared_out_ready_pin_oe),
    .ready_out_n(ready_out_n), .pulse_mode(pulse_mode), .config_restart(config_restart),
    .conversion_start(conversion_start), .cmd_strobe(cmd_strobe), .cmd_byte(cmd_byte));
`default_nettype wire

// ### cdr_spi_ctrl.sv
// Purpose: Serial controller model driving the readout port
// Assumes: Serial clock idles low, 320 ns period
// Notes:   Timing is free running, unrelated to the block clock
`timescale 1ns/10ps
`default_nettype none
module cdr_spi_ctrl (
    // Controller lines
    output var logic cs_n_pin,
    output var logic sclk_pin,
    output var logic din_pin,
    // Line returned by the device
    input wire logic pin_wire
);
    initial begin
        cs_n_pin = 1'b1;
        sclk_pin = 1'b0;
        din_pin = 1'b0;
    end
    task automatic select(input logic lvl);
        #13 cs_n_pin = lvl;
        #200;
    endtask
    // Data set while clock low, so the device takes it on the falling edge
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        #13;
        for (int i = 7; i >= 0; i--) begin
            din_pin = tx[i];
            #40 sclk_pin = 1'b1;
            #160 sclk_pin = 1'b0;
            #120 rx[i] = pin_wire;
        end
        din_pin = 1'b0;
    endtask
    task automatic bits(input int n);
        repeat (n) begin
            #40 sclk_pin = 1'b1;
            #160 sclk_pin = 1'b0;
            #120;
        end
    endtask
endmodule
`default_nettype wire

// ### tb_top.sv
// Purpose: Self-checking bench of the readout port
// Assumes: Status and checksum bytes enabled until the last scenario, timeout shortened to 200
// Notes:   Expected bytes are built from the pushed words
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic        clock = 1'b0;
    logic        reset_n = 1'b0;
    wire         cs_n_pin, sclk_pin, din_pin, pin, pin_oe, ready_out_n, prim_ready, cmd_strobe, pin_wire;
    wire  [7:0]  cmd_byte;
    logic        timeout_enable = 1'b0, pulse_mode = 1'b0, config_restart = 1'b0, conversion_start = 1'b0;
    logic        status_enable = 1'b1, checksum_enable = 1'b1;
    logic        reg_access_busy = 1'b0, prim_valid = 1'b0, aux_valid = 1'b0, last_pin = 1'b1, refused = 1'b0;
    logic [31:0] prim_data = 32'h0;
    logic [23:0] aux_data = 24'h9c3b71;
    logic [7:0]  got_cmd = 8'h00;
    logic [7:0]  rx;
    int          n_mismatch = 0, checks_done = 0, cycles = 0;

    cdr_readout_port #(.TIMEOUT_CYCLES(17'd200)) dut_u (.clock(clock), .reset_n(reset_n), .cs_n_pin(cs_n_pin),
        .sclk_pin(sclk_pin), .din_pin(din_pin), .shared_out_ready_pin(pin), .shared_out_ready_pin_oe(pin_oe),
        .ready_out_n(ready_out_n), .timeout_enable(timeout_enable), .status_enable(status_enable),
        .checksum_enable(checksum_enable),
        .pulse_mode(pulse_mode), .reg_access_busy(reg_access_busy), .config_restart(config_restart),
        .conversion_start(conversion_start), .status_low(6'h2d), .prim_valid(prim_valid), .prim_ready(prim_ready),
        .prim_data(prim_data), .aux_valid(aux_valid), .aux_data(aux_data), .cmd_strobe(cmd_strobe), .cmd_byte(cmd_byte));
    cdr_spi_ctrl ctrl_u (.cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin), .din_pin(din_pin), .pin_wire(pin_wire));
    // A released pin shows the inverse of its last driven level
    assign pin_wire = pin_oe ? pin : ~last_pin;

    initial begin
        forever #20 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (pin_oe) last_pin <= pin;
        if (cmd_strobe) got_cmd <= cmd_byte;
        if (cycles == 40000) begin
            n_mismatch++;
            finish_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic at_neg(input int n);
        cyc(n);
        @(negedge clock);
    endtask
    task automatic pulse_in(input bit start);
        @(posedge clock);
        config_restart <= !start;
        conversion_start <= start;
        cyc(1);
        config_restart <= 1'b0;
        conversion_start <= 1'b0;
        at_neg(1);
    endtask
    task automatic push(input logic [31:0] w);
        prim_data <= w;
        prim_valid <= 1'b1;
        @(negedge clock);
        while (prim_ready !== 1'b1) begin
            refused = 1'b1;
            @(negedge clock);
        end
        @(posedge clock);
    endtask
    task automatic rd6(input logic [7:0] st, input logic [31:0] w);
        logic [7:0] e [6];
        e = '{st, w[31:24], w[23:16], w[15:8], w[7:0], w[31:24] + w[23:16] + w[15:8] + w[7:0]};
        for (int i = 0; i < 6; i++) begin
            ctrl_u.xfer(8'h00, rx);
            chk("readout byte", e[i], rx);
        end
        cyc(1);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic test_direct();
        push(32'h81234e5f);
        prim_valid <= 1'b0;
        at_neg(3);
        chk("ready on result", 0, ready_out_n);
        chk("shared pin on result", 0, pin_wire);
        rd6(8'h6d, 32'h81234e5f);
        chk("ready after falling edge", 1, ready_out_n);
        rd6(8'h2d, 32'h81234e5f);
    endtask
    task automatic test_cmd();
        logic [7:0] code [4] = '{8'h12, 8'h13, 8'h14, 8'h15};
        logic [7:0] st [4] = '{8'had, 8'had, 8'h80, 8'h00};
        aux_valid <= 1'b1;
        cyc(1);
        aux_valid <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            ctrl_u.xfer(code[i], rx);
            rd6(st[i], (i < 2) ? 32'h81234e5f : {aux_data, 8'h00});
        end
    endtask
    task automatic test_restart();
        push(32'h0badf00d);
        prim_valid <= 1'b0;
        at_neg(3);
        chk("ready before restart", 0, ready_out_n);
        pulse_in(1'b0);
        chk("ready after restart", 1, ready_out_n);
        cyc(30);
    endtask
    task automatic test_fifo();
        for (int i = 0; i < 10; i++) push(32'h5a000000 + i);
        prim_valid <= 1'b0;
        chk("buffer refused", 1, refused);
        at_neg(400);
        chk("ready while unread", 0, ready_out_n);
        ctrl_u.xfer(8'h12, rx);
        chk("ready after opcode", 1, ready_out_n);
        rd6(8'h6d, 32'h5a000009);
    endtask
    task automatic test_pulse();
        pulse_mode <= 1'b1;
        push(32'h13572468);
        prim_valid <= 1'b0;
        at_neg(20);
        chk("ready held low", 0, ready_out_n);
        pulse_in(1'b1);
        chk("ready on conversion start", 1, ready_out_n);
        @(posedge clock);
        pulse_mode <= 1'b0;
        cyc(2);
    endtask
    task automatic test_autoreset();
        timeout_enable <= 1'b1;
        cyc(2);
        ctrl_u.bits(1);
        cyc(260);
        cyc(4);
        ctrl_u.xfer(8'h12, rx);
        rd6(8'h6d, 32'h13572468);
        timeout_enable <= 1'b0;
    endtask
    task automatic test_cmd_cs();
        ctrl_u.xfer(8'ha5, rx);
        at_neg(6);
        chk("forwarded command", 8'ha5, got_cmd);
        ctrl_u.bits(3);
        ctrl_u.select(1'b1);
        at_neg(5);
        chk("pin released", 0, pin_oe);
        ctrl_u.select(1'b0);
        cyc(5);
        push(32'h2468ace1);
        prim_valid <= 1'b0;
        cyc(3);
        rd6(8'h6d, 32'h2468ace1);
    endtask
    task automatic test_busy();
        logic [31:0] w = 32'h7e5a3c01;
        status_enable <= 1'b0;
        checksum_enable <= 1'b0;
        reg_access_busy <= 1'b1;
        push(w);
        prim_valid <= 1'b0;
        cyc(3);
        reg_access_busy <= 1'b0;
        for (int i = 3; i >= 0; i--) begin
            ctrl_u.xfer(8'h00, rx);
            chk("shift register kept", 32'h2468ace1 >> (8 * i) & 32'hff, rx);
        end
        ctrl_u.xfer(8'h12, rx);
        for (int i = 3; i >= 0; i--) begin
            ctrl_u.xfer(8'h00, rx);
            chk("holding register", w >> (8 * i) & 32'hff, rx);
        end
    endtask
    task automatic finish_test();
        $display("mismatches %0d checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        cyc(5);
        reset_n <= 1'b1;
        at_neg(2);
        chk("ready after reset", 1, ready_out_n);
        chk("pin enable after reset", 0, pin_oe);
        ctrl_u.select(1'b0);
        cyc(4);
        test_direct();
        test_cmd();
        test_restart();
        test_fifo();
        test_pulse();
        test_autoreset();
        test_cmd_cs();
        test_busy();
        finish_test();
    end
endmodule
`default_nettype wire
